// ===== eep_top.sv
`timescale 1ns/100ps
`include "eep_map.svh"
module eep_top
  import eep_pkg::*;
#(
  parameter logic [3:0]  DEV_TYPE       = 4'h6, // Arbitrary neutral value
  parameter int unsigned PROG_SHORT_CYC = `EEP_TW_MS * (`EEP_NS_PER_MS / `EEP_CLK_NS),
  parameter int unsigned PROG_LONG_CYC  = `EEP_TW_LONG_MS * (`EEP_NS_PER_MS / `EEP_CLK_NS)
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] chip_select_inputs,
  input  wire logic       write_mode_select,
  input  wire logic       write_inhibit_input,
  input  wire logic       protect_enable_input,
  output logic            busy
);
  import eep_pkg::*;

  localparam logic [19:0] LIM_SHORT = 20'(PROG_SHORT_CYC - 1);
  localparam logic [19:0] LIM_LONG  = 20'(PROG_LONG_CYC - 1);

  eep_top_st_t r_reg;
  eep_top_st_t r_next;

  // ----------------------------------------------------------------
  // Bus events and helpers
  // ----------------------------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       mode_multi;
  logic       prot_on;
  logic [8:0] boundary;
  logic       sel_match;
  logic       load_byte;
  logic       mem_we;
  logic       mem_re;
  logic [7:0] mem_rdata;
  logic       mem_rvalid;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       buf_flush;
  logic [8:0] chk_addr;

  assign scl_rise   = r_reg.scl_s & ~r_reg.scl_d;
  assign scl_fall   = ~r_reg.scl_s & r_reg.scl_d;
  assign start_c    = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_s & r_reg.sda_d;
  assign stop_c     = r_reg.scl_s & r_reg.scl_d & r_reg.sda_s & ~r_reg.sda_d;
  assign mode_multi = r_reg.pin_s[2];
  assign prot_on    = r_reg.pin_s[4] & ~r_reg.ptr[`EEP_FLAG_BIT];
  assign boundary   = {1'b1, r_reg.ptr[7:3], 3'b000};
  assign sel_match  = (r_reg.shift[7:4] == DEV_TYPE)
                    & (r_reg.shift[3:2] == r_reg.pin_s[1:0]);
  // Multibyte checks its start address only, so it can spill past the line
  assign chk_addr   = (mode_multi && r_reg.nbytes != 4'h0) ? r_reg.first_addr
                                                          : r_reg.addr;
  assign mem_we     = (r_reg.state == ST_PROG) && (r_reg.commit_idx < r_reg.nbytes)
                    && r_reg.lat_ok[r_reg.commit_idx[2:0]];
  assign mem_re     = r_reg.fetch_req & buf_in_ready;
  assign buf_flush  = start_c | (r_reg.state == ST_IDLE);
  assign load_byte  = scl_fall & ~start_c & ~stop_c
                    & (((r_reg.state == ST_DEVACK) & r_reg.rd) | (r_reg.state == ST_RACK));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.scl_m = scl_in;
    r_next.scl_s = r_reg.scl_m;
    r_next.scl_d = r_reg.scl_s;
    r_next.sda_m = sda_in;
    r_next.sda_s = r_reg.sda_m;
    r_next.sda_d = r_reg.sda_s;
    r_next.pin_m = {protect_enable_input, write_inhibit_input, write_mode_select,
                    chip_select_inputs};
    r_next.pin_s = r_reg.pin_m;
    r_next.sda_out = 1'b0;
    r_next.fetch_req = r_reg.fetch_req & ~buf_in_ready;
    if (r_reg.state == ST_PROG) begin
      // Bus is deaf here; a polling master sees no ack on its select byte
      if (r_reg.commit_idx < r_reg.nbytes) begin
        if (mem_we && r_reg.lat_addr[r_reg.commit_idx[2:0]] == `EEP_PTR_ADDR) begin
          r_next.ptr = r_reg.lat_data[r_reg.commit_idx[2:0]];
        end
        r_next.commit_idx = r_reg.commit_idx + 4'h1;
      end
      r_next.prog_cnt = r_reg.prog_cnt + 20'h1;
      if (r_reg.prog_cnt == (r_reg.long_cyc ? LIM_LONG : LIM_SHORT)) begin
        r_next.state = ST_IDLE;
        r_next.busy  = 1'b0;
      end
    end else if (start_c) begin
      r_next.state   = ST_DEVSEL;
      r_next.bit_cnt = 4'h0;
      r_next.sda_oe  = 1'b0;
      r_next.fetch_req = 1'b0;
    end else if (stop_c) begin
      r_next.sda_oe = 1'b0;
      r_next.state  = ST_IDLE;
      if ((r_reg.state == ST_WDATA || r_reg.state == ST_WACK)
          && r_reg.nbytes != 4'h0 && !r_reg.inhibit) begin
        r_next.state      = ST_PROG;
        r_next.busy       = 1'b1;
        r_next.prog_cnt   = 20'h0;
        r_next.commit_idx = 4'h0;
      end
    end else begin
      unique case (r_reg.state)
        ST_IDLE: begin
        end
        ST_DEVSEL, ST_ADDR, ST_WDATA: begin
          if (scl_rise && r_reg.bit_cnt != `EEP_BITS_PER_BYTE) begin
            r_next.shift   = {r_reg.shift[6:0], r_reg.sda_s};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall && r_reg.bit_cnt == `EEP_BITS_PER_BYTE) begin
            r_next.sda_oe = 1'b1;
            if (r_reg.state == ST_DEVSEL) begin
              if (sel_match) begin
                r_next.state   = ST_DEVACK;
                r_next.addr[8] = r_reg.shift[1];
                r_next.rd      = r_reg.shift[0];
                r_next.fetch_req = r_reg.shift[0];
              end else begin
                r_next.sda_oe = 1'b0;
                r_next.state  = ST_IDLE;
              end
            end else if (r_reg.state == ST_ADDR) begin
              r_next.addr[7:0] = r_reg.shift;
              r_next.state     = ST_ADDRACK;
              r_next.nbytes    = 4'h0;
              r_next.lat_idx   = 3'h0;
              r_next.long_cyc  = 1'b0;
              r_next.inhibit   = r_reg.pin_s[3];
            end else begin
              r_next.state = ST_WACK;
              r_next.lat_addr[r_reg.lat_idx] = r_reg.addr;
              r_next.lat_data[r_reg.lat_idx] = r_reg.shift;
              r_next.lat_ok[r_reg.lat_idx]   = !(prot_on && chk_addr >= boundary);
              r_next.lat_idx = r_reg.lat_idx + 3'h1;
              if (r_reg.nbytes == 4'h0) begin
                r_next.first_addr = r_reg.addr;
              end else if (mode_multi && r_reg.addr[7:2] != r_reg.first_addr[7:2]) begin
                r_next.long_cyc = 1'b1;
              end
              if (r_reg.nbytes != `EEP_LAT_DEPTH) begin
                r_next.nbytes = r_reg.nbytes + 4'h1;
              end
              if (mode_multi) begin
                r_next.addr[7:0] = r_reg.addr[7:0] + 8'h1;
              end else begin
                r_next.addr[2:0] = r_reg.addr[2:0] + 3'h1;
              end
            end
          end
        end
        ST_DEVACK, ST_ADDRACK, ST_WACK: begin
          if (scl_fall) begin
            r_next.sda_oe  = 1'b0;
            r_next.bit_cnt = 4'h0;
            if (r_reg.state == ST_DEVACK) begin
              r_next.state = r_reg.rd ? ST_RDATA : ST_ADDR;
            end else begin
              r_next.state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bit_cnt == `EEP_BITS_PER_BYTE) begin
              r_next.sda_oe = 1'b0;
              r_next.state  = ST_RACK;
            end else begin
              r_next.shift  = {r_reg.shift[6:0], 1'b1};
              r_next.sda_oe = ~r_reg.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (r_reg.sda_s) begin
              r_next.state = ST_IDLE;
            end else begin
              r_next.fetch_req = 1'b1;
            end
          end
        end
        default: begin
          r_next.state  = ST_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
    if (load_byte) begin
      // Counter steps as the byte goes out; the address set by a dummy write survives
      r_next.shift   = buf_out_data;
      r_next.sda_oe  = ~buf_out_data[7];
      r_next.addr    = r_reg.addr + 9'h1;
      r_next.bit_cnt = 4'h0;
      r_next.state   = ST_RDATA;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                 sda_d: 1'b1, state: ST_IDLE, ptr: `EEP_PTR_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Array and read prefetch
  // ----------------------------------------------------------------
  eep_mem u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .we     (mem_we),
    .waddr  (r_reg.lat_addr[r_reg.commit_idx[2:0]]),
    .wdata  (r_reg.lat_data[r_reg.commit_idx[2:0]]),
    .re     (mem_re),
    .raddr  (r_reg.addr),
    .rdata  (mem_rdata),
    .rvalid (mem_rvalid)
  );

  // Two slots so a fetch never has to wait on the shifter
  eep_buf u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (buf_flush),
    .in_valid  (mem_rvalid),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_out_valid),
    .out_ready (load_byte),
    .out_data  (buf_out_data)
  );

  assign sda_out = r_reg.sda_out;
  assign sda_oe  = r_reg.sda_oe;
  assign busy    = r_reg.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic sel_end;
  assign sel_end = (r_reg.state == ST_DEVSEL) && scl_fall && !start_c && !stop_c
                 && (r_reg.bit_cnt == `EEP_BITS_PER_BYTE);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_type_mismatch: assert property (sel_end && r_reg.shift[7:4] != DEV_TYPE
    |=> !sda_oe && r_reg.state == ST_IDLE) else $error("type mismatch acked");
  a_cs_mismatch: assert property (sel_end && r_reg.shift[3:2] != r_reg.pin_s[1:0]
    |=> r_reg.state == ST_IDLE) else $error("chip select mismatch acked");
  a_block_bit: assert property (sel_end && sel_match
    |=> r_reg.addr[8] == $past(r_reg.shift[1])) else $error("block bit lost");
  a_dir_bit: assert property (sel_end && sel_match
    |=> r_reg.rd == $past(r_reg.shift[0]) && sda_oe) else $error("direction or ack wrong");
  a_prog_silent: assert property (r_reg.state == ST_PROG
    |-> !sda_oe && busy) else $error("bus driven while programming");
  a_prog_len: assert property (r_reg.state == ST_PROG
    |-> r_reg.prog_cnt <= LIM_LONG) else $error("program cycle too long");
  a_nack_ends: assert property ((r_reg.state == ST_RACK) && scl_rise && r_reg.sda_s
    && !start_c && !stop_c |=> r_reg.state == ST_IDLE ##1 !sda_oe)
    else $error("read not ended on nack");
  a_read_step: assert property (load_byte
    |=> r_reg.addr == $past(r_reg.addr) + 9'h1) else $error("counter not stepped");
  a_page_wrap: assert property ((r_reg.state == ST_WDATA) && scl_fall && !mode_multi
    && !start_c && !stop_c && r_reg.bit_cnt == `EEP_BITS_PER_BYTE
    |=> r_reg.addr[8:3] == $past(r_reg.addr[8:3])) else $error("page left row");
  a_inhibit_hold: assert property (mem_we |-> !r_reg.inhibit)
    else $error("write while inhibited");
  // Prefetch must land before the clock fall; a too fast master outruns it
  a_fetch_ready: assert property (load_byte |-> buf_out_valid)
    else $error("read byte loaded before prefetch arrived");

  c_prog_done: cover property (r_reg.state == ST_PROG ##1 r_reg.state == ST_IDLE);
  c_seq_read: cover property (load_byte && r_reg.state == ST_RACK);
  c_sel_nack: cover property (sel_end && !sel_match);
endmodule

// ===== eep_map.svh
`ifndef EEP_MAP_SVH
`define EEP_MAP_SVH
`define EEP_PTR_ADDR      9'h1ff
`define EEP_PTR_RESET     8'hff
`define EEP_CELL_RESET    8'hff
`define EEP_FLAG_BIT      2
`define EEP_BITS_PER_BYTE 4'h8
`define EEP_LAT_DEPTH     4'h8
`define EEP_MEM_WORDS     512
`define EEP_CLK_NS        20
`define EEP_NS_PER_MS     1000000
`define EEP_TW_MS         10
`define EEP_TW_LONG_MS    20
`define EEP_BUF_FULL      2'h2
`endif

// ===== eep_pkg.sv
package eep_pkg;
`include "eep_map.svh"
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DEVSEL  = 4'b0001,
    ST_DEVACK  = 4'b0010,
    ST_ADDR    = 4'b0011,
    ST_ADDRACK = 4'b0100,
    ST_WDATA   = 4'b0101,
    ST_WACK    = 4'b0110,
    ST_RDATA   = 4'b0111,
    ST_RACK    = 4'b1000,
    ST_PROG    = 4'b1001
  } eep_state_t;

  typedef struct packed {
    logic             scl_m;
    logic             scl_s;
    logic             scl_d;
    logic             sda_m;
    logic             sda_s;
    logic             sda_d;
    logic [4:0]       pin_m;
    logic [4:0]       pin_s;
    eep_state_t       state;
    logic [3:0]       bit_cnt;
    logic [7:0]       shift;
    logic             rd;
    logic [8:0]       addr;
    logic [8:0]       first_addr;
    logic [3:0]       nbytes;
    logic [2:0]       lat_idx;
    logic [7:0][8:0]  lat_addr;
    logic [7:0][7:0]  lat_data;
    logic [7:0]       lat_ok;
    logic             long_cyc;
    logic             inhibit;
    logic [3:0]       commit_idx;
    logic [19:0]      prog_cnt;
    logic [7:0]       ptr;
    logic             fetch_req;
    logic             sda_oe;
    logic             sda_out;
    logic             busy;
  } eep_top_st_t;

  typedef struct packed {
    logic [1:0][7:0] data;
    logic            wp;
    logic            rp;
    logic [1:0]      cnt;
  } eep_buf_st_t;

  typedef struct packed {
    logic [`EEP_MEM_WORDS-1:0][7:0] cells;
    logic [7:0]                     rdata;
    logic                           rvalid;
  } eep_mem_st_t;
endpackage

// ===== eep_mem.sv
`timescale 1ns/100ps
module eep_mem
  import eep_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       we,
  input  wire logic [8:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic       re,
  input  wire logic [8:0] raddr,
  output logic      [7:0] rdata,
  output logic            rvalid
);
  import eep_pkg::*;
  eep_mem_st_t r_reg;
  eep_mem_st_t r_next;

  // Cells come up erased, like a part fresh from delivery
  always_comb begin
    r_next = r_reg;
    r_next.rvalid = re;
    if (re) begin
      r_next.rdata = r_reg.cells[raddr];
    end
    if (we) begin
      r_next.cells[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{cells: {`EEP_MEM_WORDS{`EEP_CELL_RESET}}, rdata: `EEP_CELL_RESET, rvalid: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata  = r_reg.rdata;
  assign rvalid = r_reg.rvalid;
endmodule

// ===== eep_buf.sv
`timescale 1ns/100ps
module eep_buf
  import eep_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       flush,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);
  import eep_pkg::*;
  eep_buf_st_t r_reg;
  eep_buf_st_t r_next;
  logic push;
  logic pop;

  assign in_ready  = (r_reg.cnt != `EEP_BUF_FULL);
  assign out_valid = (r_reg.cnt != 2'h0);
  assign out_data  = r_reg.data[r_reg.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.data[r_reg.wp] = in_data;
      r_next.wp = ~r_reg.wp;
    end
    if (pop) begin
      r_next.rp = ~r_reg.rp;
    end
    r_next.cnt = r_reg.cnt + {1'b0, push} - {1'b0, pop};
    // Stale prefetch must not survive a new frame
    if (flush) begin
      r_next.wp  = 1'b0;
      r_next.rp  = 1'b0;
      r_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule

// ===== eep_i2c_master.sv
`timescale 1ns/100ps
module eep_i2c_master (
  input  wire logic clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output logic      sda
);
  logic sda_m;
  // Open-drain line with pull-up: a released line reads high
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Also a repeated START when entered with the clock low
  task automatic start();
    tick(2);
    sda_m = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b0;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_m = 1'b1;
    tick(4);
  endtask
  // Data moves only while the clock is low; sampled late in the high phase
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_m = b;
    tick(2);
    scl = 1'b1;
    tick(3);
    r = sda;
    tick(1);
    scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~more, r);
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  import eep_pkg::*;
  localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value
  localparam int T_SHORT = 200;
  localparam int T_LONG  = 400;
  logic       clk, rst_n, scl, sda, sda_out, sda_oe, busy;
  logic [1:0] cs_pins;
  logic       mode, inhibit, prot_en;
  logic [7:0] mem_exp [512];
  logic [15:0] lfsr_st;
  logic [8:0] cur;
  int         num_errors, checks_done, busy_cnt;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (busy === 1'b1) busy_cnt++;
  end
  eep_top #(.DEV_TYPE(TYPE_CODE), .PROG_SHORT_CYC(T_SHORT), .PROG_LONG_CYC(T_LONG)) DUT (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_inputs(cs_pins), .write_mode_select(mode),
    .write_inhibit_input(inhibit), .protect_enable_input(prot_en), .busy(busy));
  eep_i2c_master M (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
    return lfsr_st[7:0];
  endfunction
  function automatic logic [7:0] sel(input logic [8:0] a, input logic rw, input logic [1:0] c);
    return {TYPE_CODE, c, a[8], rw};
  endfunction
  function automatic logic [8:0] waddr(input logic [8:0] a, input int i, input logic multi);
    logic [7:0] s;
    s = a[7:0] + 8'(i);
    return multi ? {a[8], s} : {a[8:3], s[2:0]};
  endfunction
  function automatic logic blocked(input logic [8:0] p);
    return prot_en && !mem_exp[9'h1ff][2] && p >= {1'b1, mem_exp[9'h1ff][7:3], 3'b000};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [8:0] a, input int n, input logic multi);
    logic ack, lng, blk;
    logic [7:0] dv [8];
    logic [8:0] pv [8];
    logic       keep [8];
    mode = multi;
    blk = blocked(a);
    M.start();
    M.send(sel(a, 1'b0, cs_pins), ack);
    chk("sel ack", 16'(ack), 16'h0001);
    M.send(a[7:0], ack);
    chk("addr ack", 16'(ack), 16'h0001);
    for (int i = 0; i < n; i++) begin
      pv[i] = waddr(a, i, multi);
      dv[i] = (pv[i] == 9'h1ff) ? 8'hf0 : rnd();
      keep[i] = !inhibit && !(multi ? blk : blocked(pv[i]));
      M.send(dv[i], ack);
      chk("data ack", 16'(ack), 16'h0001);
    end
    for (int i = 0; i < n; i++) begin
      if (keep[i]) mem_exp[pv[i]] = dv[i];
    end
    lng = multi && (pv[0][7:2] != pv[n-1][7:2]);
    busy_cnt = 0;
    M.stop();
    M.tick(20);
    // Poll while programming: no answer expected
    if (busy === 1'b1) begin
      M.start();
      M.send(sel(a, 1'b0, cs_pins), ack);
      chk("poll ack", 16'(ack), 16'h0000);
      M.stop();
    end
    for (int g = 0; g < 1000 && busy !== 1'b0; g++) M.tick(1);
    chk("prog cycles", 16'(busy_cnt), 16'(inhibit ? 0 : (lng ? T_LONG : T_SHORT)));
  endtask
  task automatic rd(input logic [8:0] a, input logic rand_rd, input int n);
    logic ack;
    logic [7:0] d;
    if (rand_rd) begin
      M.start();
      M.send(sel(a, 1'b0, cs_pins), ack);
      M.send(a[7:0], ack);
      chk("dummy ack", 16'(ack), 16'h0001);
    end
    M.start();
    M.send(sel(a, 1'b1, cs_pins), ack);
    chk("rsel ack", 16'(ack), 16'h0001);
    for (int i = 0; i < n; i++) begin
      M.recv(i < n - 1, d);
      chk("rdata", 16'(d), 16'(mem_exp[a]));
      a = a + 9'h001;
    end
    M.stop();
    cur = a;
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #1_900_000;
    num_errors++;
    results();
  end
  initial begin
    logic ack;
    logic [1:0] c;
    logic [7:0] t;
    logic [8:0] a;
    rst_n = 1'b0;
    cs_pins = 2'b10;
    mode = 1'b1;
    inhibit = 1'b0;
    prot_en = 1'b0;
    lfsr_st = 16'd61778;
    foreach (mem_exp[i]) mem_exp[i] = 8'hff;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    M.tick(4);
    chk("busy rst", 16'(busy), 16'h0000);
    chk("oe rst", 16'(sda_oe), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      cs_pins = c;
      M.start();
      M.send(sel(9'h000, 1'b0, c ^ {c[0], ~c[0]}), ack);
      chk("bad cs", 16'(ack), 16'h0000);
      M.stop();
      M.start();
      M.send({TYPE_CODE ^ (4'h1 << k), c, 2'b00}, ack);
      chk("bad type", 16'(ack), 16'h0000);
      M.stop();
      rd(9'(k), 1'b1, 1);
    end
    cs_pins = 2'b10;
    wr(9'h1a5, 1, 1'b0);
    wr(9'h0a5, 1, 1'b1);
    rd(9'h0a5, 1'b1, 1);
    rd(9'h1a5, 1'b1, 1);
    wr(9'h005, 4, 1'b1);
    wr(9'h0c0, 8, 1'b1);
    wr(9'h01c, 6, 1'b0);
    rd(9'h000, 1'b1, 12);
    rd(9'h018, 1'b1, 8);
    rd(9'h0c0, 1'b1, 8);
    for (int r = 0; r < 6; r++) begin
      t = rnd();
      a = {t[7], rnd()};
      wr(a, 1 + int'(t[1:0]), t[4]);
      rd(a, 1'b1, 5);
    end
    inhibit = 1'b1;
    wr(9'h0c0, 2, 1'b1);
    inhibit = 1'b0;
    rd(9'h0c0, 1'b1, 2);
    wr(9'h1ff, 1, 1'b0);
    rd(9'h1ff, 1'b1, 2);
    rd({1'b0, cur[7:0]}, 1'b0, 1);
    prot_en = 1'b1;
    wr(9'h1f8, 2, 1'b0);
    wr(9'h1e8, 1, 1'b0);
    wr(9'h1ef, 4, 1'b1);
    rd(9'h1e8, 1'b1, 16);
    results();
  end
endmodule
